//--- pkg/bcs_pkg.sv
package bcs_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL     = 4'h0;  // software run enable
  localparam logic [3:0] ADDR_STATUS      = 4'h4;  // phase and flags
  localparam logic [3:0] ADDR_CHARGE_TIME = 4'h8;  // charge timer terminal count
  localparam logic [3:0] ADDR_PRE_TIME    = 4'hC;  // precharge timer terminal count

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_SW_ENABLE_BIT = 0;  // software run enable
  localparam logic [31:0] CONTROL_RESET     = 32'h0000_0001;
  localparam logic [31:0] CHARGE_TIME_RESET = 32'h0001_0000;
  localparam logic [31:0] PRE_TIME_RESET    = 32'h0000_4000;

  // ----------------------------------------------------------------
  // switching timing at 25 MHz
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 25_000_000;
  localparam int SW_FREQ_HZ    = 1_000_000;  // fixed switching rate
  localparam int SW_PERIOD_CYC = CLK_HZ / SW_FREQ_HZ;  // 25 cycles
  localparam real CELL1_TARGET_V = 4.2;  // single-cell target
  localparam real CELL2_TARGET_V = 8.4;  // two-cell target
  localparam real LOW_SIDE_SYNC_A = 0.1;  // 100mA sync threshold
  localparam real PEAK_LIMIT_A    = 3.6;  // high-side peak limit

  // ----------------------------------------------------------------
  // phases and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_SLEEP, PH_IDLE, PH_PRECHARGE, PH_FAST, PH_REGULATE, PH_DONE, PH_FAULT
  } bcs_phase_t;

  typedef struct packed {
    logic supply_ok;     // adapter present
    logic charge_en_n;   // active-low enable pin
    logic therm_cold_ok; // above cold limit
    logic therm_hot_ok;  // inside hot limit
    logic therm_cut_ok;  // inside cutoff limit
    logic bat_low;       // under low_voltage_threshold
    logic bat_rch;       // under recharge threshold
    logic cur_term;      // at termination current
    logic cur_at_reg;    // voltage loop in control
    logic ovp;           // output overvoltage
    logic ttc_low;       // timer pin under enable level
    logic ttc_high;      // timer pin tied high
    logic ls_above;      // low-side current above 100mA
    logic hs_peak;       // high-side at peak limit
    logic pwm_demand;    // loop comparator wants on
    logic bat_replace;   // battery replacement seen
  } bcs_sense_t;
endpackage : bcs_pkg

//--- rtl/bcs_sequencer.sv
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module bcs_sequencer
  import bcs_pkg::*;
#(
  parameter int TIMER_W = 32  // timer counter width
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  input  wire bcs_sense_t  SENSE,
  input  wire logic        CELLS_SEL,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             STATUS_LINE_A_O,
  output logic             STATUS_LINE_A_OE_N,
  output logic             STATUS_LINE_B_O,
  output logic             STATUS_LINE_B_OE_N,
  output logic             SUPPLY_GOOD_N_O,
  output logic             SUPPLY_GOOD_N_OE_N,
  output logic             HS_GATE,
  output logic             LS_GATE,
  output logic             CELL2_SELECT,
  output logic             PRECHARGE_CURRENT_SEL,
  output logic             DETECT_CURRENT_EN
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  bcs_sense_t sense_meta_reg;  // first stage, read only by second
  bcs_sense_t s;               // second stage, used by logic
  logic       cells_meta_reg;  // first stage of cell select
  logic       cells_reg;       // synchronised cell select

  // two stages on every comparator decision
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sense_meta_reg <= '0;
      s              <= '0;
      cells_meta_reg <= 1'b0;
      cells_reg      <= 1'b0;
    end else if (CE) begin
      sense_meta_reg <= SENSE;
      s              <= sense_meta_reg;
      cells_meta_reg <= CELLS_SEL;
      cells_reg      <= cells_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers and bus
  // ----------------------------------------------------------------
  logic [31:0] control_reg;      // software enable
  logic [31:0] charge_time_reg;  // charge terminal count
  logic [31:0] pre_time_reg;     // precharge terminal count
  logic        ack_reg;          // bus acknowledge
  logic [31:0] dat_reg;          // read data
  logic        wb_req;           // new request this cycle
  bcs_phase_t  phase_reg;        // charge phase
  bcs_phase_t  phase_next;
  logic        ovp_reg;          // overvoltage held
  logic        pre_fault_reg;    // latched precharge fault
  logic        chg_fault_reg;    // latched charge timer fault
  logic        suspend;          // temperature suspend

  assign wb_req = WB_CYC_I && WB_STB_I && !ack_reg;

  // byte-lane merge helper
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // writes take effect with ack, one cycle after strobe
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      control_reg     <= CONTROL_RESET;
      charge_time_reg <= CHARGE_TIME_RESET;
      pre_time_reg    <= PRE_TIME_RESET;
    end else if (CE && wb_req && WB_WE_I) begin
      case (WB_ADR_I)
        ADDR_CONTROL:     control_reg     <= merge(control_reg, WB_DAT_I, WB_SEL_I);
        ADDR_CHARGE_TIME: charge_time_reg <= merge(charge_time_reg, WB_DAT_I, WB_SEL_I);
        ADDR_PRE_TIME:    pre_time_reg    <= merge(pre_time_reg, WB_DAT_I, WB_SEL_I);
        default: ;  // unmapped and read-only: write ignored
      endcase
    end
  end

  // ack and read data, unmapped reads give zero
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else if (CE) begin
      ack_reg <= wb_req;
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          ADDR_CONTROL:     dat_reg <= control_reg;
          ADDR_STATUS:      dat_reg <= {24'h00_0000, cells_reg, suspend, ovp_reg, chg_fault_reg,
                                        pre_fault_reg, 3'(phase_reg)};
          ADDR_CHARGE_TIME: dat_reg <= charge_time_reg;
          ADDR_PRE_TIME:    dat_reg <= pre_time_reg;
          default:          dat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;

  // ----------------------------------------------------------------
  // restart events
  // ----------------------------------------------------------------
  logic ce_n_prev_reg;   // last enable pin level
  logic rch_prev_reg;    // last recharge compare
  logic ttc_low_prev_reg;
  logic [2:0] por_pend_reg;  // power-up start, held until both sync stages fill
  logic ce_fall;         // enable falling edge
  logic ce_rise;
  logic rch_fall;        // battery dropped under recharge level
  logic ttc_rise;        // timer pin rose through enable level
  logic restart;
  logic enabled;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ce_n_prev_reg    <= 1'b0;  // same as synchroniser reset: no false edge
      rch_prev_reg     <= 1'b0;
      ttc_low_prev_reg <= 1'b0;
      por_pend_reg     <= 3'h7;
    end else if (CE) begin
      ce_n_prev_reg    <= s.charge_en_n;
      rch_prev_reg     <= s.bat_rch;
      ttc_low_prev_reg <= s.ttc_low;
      por_pend_reg     <= {por_pend_reg[1:0], 1'b0};  // stale sync data would hide it
    end
  end

  assign ce_fall  = ce_n_prev_reg && !s.charge_en_n;
  assign ce_rise  = !ce_n_prev_reg && s.charge_en_n;
  assign rch_fall = !rch_prev_reg && s.bat_rch;
  assign ttc_rise = ttc_low_prev_reg && !s.ttc_low;
  assign enabled  = !s.charge_en_n && control_reg[CTL_SW_ENABLE_BIT];
  assign restart  = rch_fall || (por_pend_reg[2] && s.bat_rch) || ce_fall || ce_rise || ttc_rise;

  // ----------------------------------------------------------------
  // safety timers
  // ----------------------------------------------------------------
  logic [TIMER_W-1:0] pre_cnt_reg;  // precharge elapsed
  logic [TIMER_W-1:0] chg_cnt_reg;  // charge elapsed
  logic timer_on;   // charge timer allowed
  logic term_on;    // termination allowed
  logic pre_exp;
  logic chg_exp;

  assign timer_on = !s.ttc_low && !s.ttc_high;
  assign term_on  = !s.ttc_low;
  assign pre_exp  = pre_cnt_reg >= TIMER_W'(pre_time_reg);
  assign chg_exp  = chg_cnt_reg >= TIMER_W'(charge_time_reg);

  // counters hold during suspend, clear on new cycle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pre_cnt_reg <= '0;
      chg_cnt_reg <= '0;
    end else if (CE) begin
      if (restart || !timer_on) begin
        pre_cnt_reg <= '0;
        chg_cnt_reg <= '0;
      end else if (!suspend) begin
        if (phase_reg == PH_PRECHARGE && !pre_exp) begin
          pre_cnt_reg <= pre_cnt_reg + 1'b1;
        end
        if ((phase_reg == PH_FAST || phase_reg == PH_REGULATE) && !chg_exp) begin
          chg_cnt_reg <= chg_cnt_reg + 1'b1;
        end
      end
    end
  end

  // fault latches: reset or enable fall clear both; replacement clears precharge, recharge drop clears charge
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pre_fault_reg <= 1'b0;
      chg_fault_reg <= 1'b0;
    end else if (CE) begin
      if (phase_reg == PH_PRECHARGE && pre_exp && timer_on && !suspend) begin
        pre_fault_reg <= 1'b1;
      end else if (s.bat_replace || ce_fall) begin
        pre_fault_reg <= 1'b0;
      end
      if (phase_reg inside {PH_FAST, PH_REGULATE} && chg_exp && timer_on && !suspend) begin
        chg_fault_reg <= 1'b1;
      end else if (rch_fall || ce_fall) begin
        chg_fault_reg <= 1'b0;
      end
    end
  end

  // overvoltage held until recharge level reached
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ovp_reg <= 1'b0;
    end else if (CE) begin
      if (s.ovp) begin
        ovp_reg <= 1'b1;
      end else if (s.bat_rch) begin
        ovp_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  logic charging;
  assign charging = phase_reg == PH_PRECHARGE || phase_reg == PH_FAST ||
                    phase_reg == PH_REGULATE;
  // thermistor windows; fixed in-window voltage keeps these true
  assign suspend = charging ? !(s.therm_cold_ok && s.therm_cut_ok)
                            : 1'b0;

  // next phase
  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      PH_SLEEP:     if (s.supply_ok) phase_next = PH_IDLE;
      PH_IDLE: begin
        // start only inside cold-to-hot window
        if (enabled && s.therm_cold_ok && s.therm_hot_ok && !ovp_reg) begin
          phase_next = s.bat_low ? PH_PRECHARGE : PH_FAST;
        end
      end
      PH_PRECHARGE: begin
        if (pre_fault_reg) phase_next = PH_FAULT;
        else if (!s.bat_low) phase_next = PH_FAST;
      end
      PH_FAST: begin
        if (chg_fault_reg) phase_next = PH_DONE;
        else if (s.cur_at_reg) phase_next = PH_REGULATE;
      end
      PH_REGULATE: begin
        if (chg_fault_reg) phase_next = PH_DONE;
        else if (term_on && s.cur_term) phase_next = PH_DONE;
      end
      PH_DONE:      if (restart) phase_next = PH_IDLE;
      PH_FAULT:     if (!pre_fault_reg) phase_next = PH_IDLE;
      default:      phase_next = PH_IDLE;
    endcase
    if (!enabled && charging) phase_next = PH_IDLE;
    if (!s.supply_ok) phase_next = PH_SLEEP;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      phase_reg <= PH_SLEEP;
    end else if (CE) begin
      phase_reg <= phase_next;
    end
  end

  // ----------------------------------------------------------------
  // fixed-frequency switching
  // ----------------------------------------------------------------
  logic [4:0] sw_cnt_reg;  // position in the 1MHz period
  logic       hs_reg;
  logic       ls_reg;
  logic       run_pwm;
  logic       cut_reg;     // peak seen in this period

  assign run_pwm = charging && !suspend && !ovp_reg;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sw_cnt_reg <= 5'h00;
    end else if (CE) begin
      sw_cnt_reg <= (sw_cnt_reg == 5'(SW_PERIOD_CYC - 1)) ? 5'h00 : sw_cnt_reg + 5'h01;
    end
  end

  // peak cut held to the period end, so one period gets one pulse
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cut_reg <= 1'b0;
    end else if (CE) begin
      if (s.hs_peak) begin
        cut_reg <= 1'b1;
      end else if (sw_cnt_reg == 5'(SW_PERIOD_CYC - 1)) begin
        cut_reg <= 1'b0;
      end
    end
  end

  // gate follows demand every clock; peak limit cuts the pulse
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hs_reg <= 1'b0;
      ls_reg <= 1'b0;
    end else if (CE) begin
      if (!run_pwm) begin
        hs_reg <= 1'b0;
        ls_reg <= 1'b0;
      end else if (s.hs_peak || cut_reg) begin
        hs_reg <= 1'b0;
        ls_reg <= s.ls_above;
      end else begin
        // duty follows demand: all-off gives 0%, all-on runs until the peak limit cuts it
        hs_reg <= s.pwm_demand;
        ls_reg <= !s.pwm_demand && s.ls_above;
      end
    end
  end
  assign HS_GATE = hs_reg;
  assign LS_GATE = ls_reg;

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      STATUS_LINE_A_OE_N    <= 1'b1;
      STATUS_LINE_B_OE_N    <= 1'b1;
      SUPPLY_GOOD_N_OE_N    <= 1'b1;
      CELL2_SELECT          <= 1'b0;
      PRECHARGE_CURRENT_SEL <= 1'b0;
      DETECT_CURRENT_EN     <= 1'b0;
    end else if (CE) begin
      STATUS_LINE_A_OE_N    <= !(run_pwm);
      STATUS_LINE_B_OE_N    <= !(phase_reg == PH_DONE && !ovp_reg);
      SUPPLY_GOOD_N_OE_N    <= phase_reg == PH_SLEEP;
      CELL2_SELECT          <= cells_reg;
      PRECHARGE_CURRENT_SEL <= phase_reg == PH_PRECHARGE;
      DETECT_CURRENT_EN     <= phase_reg == PH_FAULT;
    end
  end
  assign STATUS_LINE_A_O = 1'b0;  // open drain pulls low
  assign STATUS_LINE_B_O = 1'b0;
  assign SUPPLY_GOOD_N_O = 1'b0;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence seq_expire;
    CE && phase_reg == PH_PRECHARGE && pre_exp && timer_on && !suspend;
  endsequence

  chk_suspend_gates: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && suspend |=> !HS_GATE && !LS_GATE) else $error("switching during suspend");
  chk_suspend_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && suspend && !restart && timer_on |=> $stable(chg_cnt_reg)) else $error("timer moved");
  chk_pre_fault: assert property (@(posedge CLK) disable iff (!RST_N)
    seq_expire |=> pre_fault_reg) else $error("no precharge fault");
  chk_fault_detect: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && phase_reg == PH_FAULT |=> DETECT_CURRENT_EN) else $error("no detect current");
  chk_term_end: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && phase_reg == PH_REGULATE && term_on && s.cur_term && s.supply_ok && enabled
    |=> phase_reg == PH_DONE) else $error("termination missed");
  chk_sleep_entry: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && !s.supply_ok |=> phase_reg == PH_SLEEP ##1 SUPPLY_GOOD_N_OE_N || !CE)
    else $error("sleep not entered");
  chk_status_done: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && phase_reg == PH_DONE && !ovp_reg |=> !STATUS_LINE_B_OE_N && STATUS_LINE_A_OE_N)
    else $error("done status wrong");
  chk_peak_cut: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && s.hs_peak |=> !HS_GATE) else $error("peak limit ignored");
  chk_cut_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && cut_reg |=> !HS_GATE) else $error("pulse resumed in cut period");
  chk_ls_sync: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && !s.ls_above |=> !LS_GATE) else $error("low side on at low current");
  chk_ovp_stop: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && s.ovp |=> ovp_reg ##1 (!HS_GATE || !CE)) else $error("overvoltage ignored");
  chk_period_wrap: assert property (@(posedge CLK) disable iff (!RST_N)
    CE && sw_cnt_reg == 5'(SW_PERIOD_CYC - 1) |=> sw_cnt_reg == 5'h00 || !CE)
    else $error("period wrong");

endmodule : bcs_sequencer

//--- verif/bcs_charger_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side: battery, inductor and thermistor comparators
// ----------------------------------------------------------------
module bcs_charger_model
  import bcs_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire bcs_sense_t CMD,
  input  wire logic       HS_GATE,
  output bcs_sense_t      SENSE
);
  logic [4:0] ramp_reg;  // position in the 25-cycle period
  logic [5:0] cur_reg;   // inductor current in coarse steps

  // loop ramp, free running like the analog sawtooth
  always_ff @(posedge CLK) begin
    if (!RST_N) ramp_reg <= 5'h00;
    else ramp_reg <= (ramp_reg == 5'h18) ? 5'h00 : ramp_reg + 5'h01;
  end

  // current ramps while high side conducts, decays otherwise
  always_ff @(posedge CLK) begin
    if (!RST_N) cur_reg <= 6'h00;
    else if (HS_GATE) cur_reg <= (cur_reg == 6'h3F) ? cur_reg : cur_reg + 6'h01;
    else cur_reg <= (cur_reg == 6'h00) ? cur_reg : cur_reg - 6'h01;
  end

  // comparators; thermistor levels held as commanded, no glitches
  always_comb begin
    SENSE            = CMD;
    SENSE.pwm_demand = CMD.pwm_demand || (ramp_reg < 5'h0A);  // command forces full demand
    SENSE.hs_peak    = (cur_reg >= 6'h24);
    SENSE.ls_above   = (cur_reg > 6'h02);
  end
endmodule : bcs_charger_model

//--- verif/bcs_sequencer_tb.sv
`timescale 1ns/1ps
module bcs_sequencer_tb
  import bcs_pkg::*;
;
  typedef struct packed {logic [6:0] f; logic [6:0] e;} bcs_row_t;  // sense bits, expect
  logic        clk, rst_n, ce, cells, cyc, stb, we, ack, hs, ls;
  logic        a_oe_n, b_oe_n, pg_oe_n, cell2, pre_sel, det_en;
  logic [3:0]  adr, sel;
  logic [31:0] dat, dout, rd;
  bcs_sense_t  cmd, sense, s;
  bcs_row_t    rows [11];
  int          err_total, num_checks, n;

  bcs_sequencer bcs_sequencer_inst (.CLK(clk), .RST_N(rst_n), .CE(ce), .SENSE(sense),
    .CELLS_SEL(cells), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack),
    .STATUS_LINE_A_O(), .STATUS_LINE_A_OE_N(a_oe_n), .STATUS_LINE_B_O(),
    .STATUS_LINE_B_OE_N(b_oe_n), .SUPPLY_GOOD_N_O(), .SUPPLY_GOOD_N_OE_N(pg_oe_n),
    .HS_GATE(hs), .LS_GATE(ls), .CELL2_SELECT(cell2), .PRECHARGE_CURRENT_SEL(pre_sel),
    .DETECT_CURRENT_EN(det_en));
  bcs_charger_model bcs_charger_model_inst (.CLK(clk), .RST_N(rst_n), .CMD(cmd),
    .HS_GATE(hs), .SENSE(sense));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task close_out;
    $display("mismatches %0d comparisons %0d", err_total, num_checks);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // classic cycle; ack sampled at the edge, bounded wait
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 20);
    rd = dout;
    cyc <= 1'b0; stb <= 1'b0;
    if (k >= 20) begin err_total++; close_out; end
  endtask : wb

  task go(input int c); repeat (c) @(posedge clk); endtask : go
  task rd_st; wb(1'b0, ADDR_STATUS, 32'h0); endtask : rd_st
  // phase, suspend flag and the three open-drain enables
  task st(input logic [6:0] e);
    rd_st;
    chk({rd[2:0], rd[6], a_oe_n, b_oe_n, pg_oe_n}, e);
  endtask : st
  task hs_on(input int c, output int h);
    h = 0;
    repeat (c) begin @(posedge clk); if (hs === 1'b1) h++; end
  endtask : hs_on
  // enable pin high (no charge), then falling edge restarts
  task toggle(input bcs_sense_t t);
    t.charge_en_n = 1'b1; cmd <= t; go(8);
    chk(a_oe_n, 1'b1);
    t.charge_en_n = 1'b0; cmd <= t; go(12);
  endtask : toggle

  function automatic bcs_sense_t mk(input logic [6:0] f);  // sup low rch term reg cut hot
    bcs_sense_t r;
    r = '0;
    {r.supply_ok, r.bat_low, r.bat_rch, r.cur_term, r.cur_at_reg, r.therm_cut_ok,
     r.therm_hot_ok} = f;
    r.therm_cold_ok = 1'b1;
    return r;
  endfunction : mk

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard
  initial begin #2000000; err_total++; close_out; end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; ce = 1'b1; cells = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 4'h0; sel = 4'hF; dat = 32'h0; cmd = mk(7'h33); err_total = 0; num_checks = 0;
    rows = '{'{7'h33, 7'h07}, '{7'h73, 7'h22}, '{7'h43, 7'h32}, '{7'h47, 7'h42},
             '{7'h4F, 7'h54}, '{7'h53, 7'h32}, '{7'h41, 7'h3E}, '{7'h43, 7'h32},
             '{7'h03, 7'h07}, '{7'h52, 7'h16}, '{7'h53, 7'h32}};
    go(5);
    chk({a_oe_n, b_oe_n, pg_oe_n, hs}, 4'hE);
    rst_n <= 1'b1;
    // reset values, and an unmapped word reads zero
    wb(1'b0, ADDR_CONTROL, 32'h0);     chk(rd, CONTROL_RESET);
    wb(1'b0, ADDR_CHARGE_TIME, 32'h0); chk(rd, CHARGE_TIME_RESET);
    wb(1'b0, ADDR_PRE_TIME, 32'h0);    chk(rd, PRE_TIME_RESET);
    wb(1'b0, 4'h1, 32'h0);             chk(rd, 32'h0);
    // phase walk: sleep, precharge, fast, regulate, done, restart, suspend, start gate
    foreach (rows[i]) begin
      cmd <= mk(rows[i].f); go(12);
      st(rows[i].e);
    end
    // cell count select
    cells <= 1'b1; go(6); chk(cell2, 1'b1);
    rd_st; chk(rd[7], 1'b1);
    cells <= 1'b0; go(6); chk(cell2, 1'b0);
    // suspend holds the charge timer; timer pin rise restarts it
    wb(1'b1, ADDR_CHARGE_TIME, 32'h0000_0064);
    s = mk(7'h43); s.ttc_low = 1'b1; cmd <= s; go(6);
    s.ttc_low = 1'b0; cmd <= s; go(30);
    s.therm_cut_ok = 1'b0; cmd <= s; go(5);
    hs_on(200, n); chk(n, 0);
    s.therm_cut_ok = 1'b1; cmd <= s; go(15);
    st(7'h32);
    hs_on(50, n); chk(n != 0, 1'b1);
    go(40); rd_st; chk(rd[2:0], 3'h5);
    // one byte lane restores a long count
    sel <= 4'h4; wb(1'b1, ADDR_CHARGE_TIME, 32'h0001_0000); sel <= 4'hF;
    wb(1'b0, ADDR_CHARGE_TIME, 32'h0); chk(rd, 32'h0001_0064);
    // low timer pin masks termination, high pin keeps it
    s = mk(7'h4F); s.ttc_low = 1'b1; toggle(s);
    rd_st; chk(rd[2:0], 3'h4);
    s.ttc_low = 1'b0; s.ttc_high = 1'b1; cmd <= s; go(12);
    rd_st; chk(rd[2:0], 3'h5);
    // precharge timeout, cleared by replacement then by enable fall
    wb(1'b1, ADDR_PRE_TIME, 32'h0000_0028);
    for (int k = 0; k < 2; k++) begin
      s = mk(7'h73); toggle(s); chk(pre_sel, 1'b1);
      go(60); rd_st; chk({rd[3], rd[2:0]}, 4'hE);
      chk({det_en, a_oe_n, b_oe_n}, 3'h7);
      s.bat_low = 1'b0; s.bat_rch = 1'b0; cmd <= s; go(12);
      rd_st; chk(rd[2:0], 3'h6);
      if (k == 0) begin
        s.bat_replace = 1'b1; cmd <= s; go(4); s.bat_replace = 1'b0; cmd <= s;
      end else toggle(s);
      go(12); rd_st; chk(rd[3], 1'b0);
    end
    // overvoltage stops switching until the recharge level
    s = mk(7'h43); cmd <= s; go(12);
    s.ovp = 1'b1; cmd <= s; go(8);
    hs_on(30, n); chk(n, 0);
    chk(ls, 1'b0);
    rd_st; chk({rd[5], a_oe_n, b_oe_n}, 3'h7);
    s.ovp = 1'b0; cmd <= s; go(12); rd_st; chk(rd[5], 1'b1);
    s.bat_rch = 1'b1; cmd <= s; go(12); rd_st; chk(rd[5], 1'b0);
    // full demand: only the peak limit can keep the high side from staying on
    s.pwm_demand = 1'b1; cmd <= s; go(4);
    hs_on(150, n); chk(n > 0 && n < 150, 1'b1);
    // enable low freezes the precharge timer, then it faults
    s = mk(7'h73); toggle(s); ce <= 1'b0; go(80);
    ce <= 1'b1; chk(pre_sel, 1'b1);
    go(60); chk(det_en, 1'b1);
    // mid-run reset releases the lines and clears the latched fault
    rst_n <= 1'b0; go(5); chk({a_oe_n, b_oe_n, pg_oe_n, det_en}, 4'hE);
    rst_n <= 1'b1; rd_st; chk(rd[3:0], 4'h0);
    close_out;
  end
endmodule : bcs_sequencer_tb
